// File: ascs_fifo.sv
// Word FIFO that holds conversion results until the host reads them
`timescale 1ns/1ps
module ascs_fifo
#(
    parameter int WIDTH = 24,
    parameter int DEPTH = 16
)
(
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // Filling side
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    // Draining side
    output logic [WIDTH-1:0]      out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);

    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];                    // Word storage
    logic [PW-1:0]    wr_ptr;                         // Next slot to fill
    logic [PW-1:0]    rd_ptr;                         // Oldest word
    logic [CW-1:0]    count;                          // Words held
    logic [CW-1:0]    next_count;                     // Count after this edge
    logic             push;                           // Word accepted
    logic             pop;                            // Word removed

    assign push     = in_valid & in_ready;
    assign pop      = out_valid & out_ready;
    assign out_data = mem[rd_ptr];

    // Count follows pushes and pops
    always_comb
    begin
        next_count = count;
        if (push & ~pop)
            next_count = count + CW'(1);
        else if (pop & ~push)
            next_count = count - CW'(1);
    end

    // Storage write, no reset needed on data
    always_ff @(posedge clk)
    begin
        if (push)
            mem[wr_ptr] <= in_data;
    end

    // Pointers, count and flags
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wr_ptr    <= '0;
            rd_ptr    <= '0;
            count     <= '0;
            in_ready  <= 1'b0;
            out_valid <= 1'b0;
        end
        else
        begin
            if (push)
                wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + PW'(1);
            if (pop)
                rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + PW'(1);
            count     <= next_count;
            in_ready  <= (next_count != FULL_COUNT);
            out_valid <= (next_count != '0);
        end
    end

endmodule

// File: ascs_host_model.sv
// Host model driving strobes, select, mode and the host serial clock
`timescale 1ns/1ps
module ascs_host_model
(
    // Clock and resolved lines
    input  wire logic clk,
    input  wire logic sclk_w,
    input  wire logic sdo_w,
    // Host pins, idle at time zero
    output logic      mode = 1'b0,
    output logic      rfs_n = 1'b1,
    output logic      tfs_n = 1'b1,
    output logic      sel = 1'b0,
    output logic      h_sclk = 1'b1,
    output logic      h_sclk_oe = 1'b1,
    output logic      sdi = 1'b0
);
    // One frame; bits captured where the clock rises in self mode, at the end of the high phase in external mode
    task automatic xfer(input logic md, rd, sl, bst, input logic [23:0] wr, input int nb,
                        output logic [23:0] got, output int rises);
        logic prev;
        int   idle;
        got = 24'h00_0000;
        rises = 0;
        idle = 0;
        prev = 1'b1;
        @(negedge clk);
        mode = md;
        sel = sl;
        sdi = wr[23];
        h_sclk_oe = !md;
        repeat (4) @(negedge clk);
        if (rd)
            rfs_n = 1'b0;
        else
            tfs_n = 1'b0;
        if (md)
        begin
            while (rises < nb && idle < 16)
            begin
                @(negedge clk);
                idle++;
                if (sclk_w && !prev)
                begin
                    got = {got[22:0], sdo_w};
                    rises++;
                    idle = 0;
                    sdi = wr[23 - (rises % 24)];
                end
                prev = sclk_w;
            end
        end
        else
        begin
            repeat (6) @(negedge clk);
            for (int i = 0; i < nb; i++)
            begin
                if (bst && i > 0 && i % 8 == 0)
                    repeat (12) @(negedge clk);
                h_sclk = 1'b0;
                sdi = wr[23 - i];
                repeat (4) @(negedge clk);
                h_sclk = 1'b1;
                repeat (4) @(negedge clk);
                got = {got[22:0], sdo_w};
                rises++;
            end
        end
        // Select held until the strobe is back high
        repeat (8) @(negedge clk);
        rfs_n = 1'b1;
        tfs_n = 1'b1;
        repeat (8) @(negedge clk);
    endtask
endmodule

// File: ascs_pkg.sv
// Constants and types shared by the converter serial port front end
package ascs_pkg;

    // ************************************************************
    // Clock and serial timing
    // ************************************************************
    localparam int CLK_PERIOD_NS = 40;                // Own clock period
    localparam int SCLK_HALF_NS  = 80;                // Least half period of generated serial clock
    localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [1:0] HALF_CNT_LAST = 2'(SCLK_HALF_CYC - 1);
    localparam logic [1:0] HALF_CNT_RESET = 2'h0;

    // ************************************************************
    // Word format
    // ************************************************************
    localparam int WORD_BITS  = 24;                   // Bits in every serial word
    localparam int FIFO_DEPTH = 16;                   // Conversion words held ahead of reading
    localparam logic [4:0] BIT_CNT_RESET = 5'h00;     // First bit of a word
    localparam logic [4:0] LAST_BIT_IDX  = 5'h17;     // Bit count of the final bit
    localparam logic [23:0] CTRL_RESET   = 24'h00_0000;
    localparam logic [23:0] CAL_RESET    = 24'h00_0000;
    localparam logic [23:0] EMPTY_WORD   = 24'h00_0000;

    // ************************************************************
    // Pin synchroniser layout
    // ************************************************************
    localparam int PIN_COUNT = 6;
    localparam int PIN_MODE  = 0;                     // Clocking mode select
    localparam int PIN_RFS   = 1;                     // Receive frame strobe, low active
    localparam int PIN_TFS   = 2;                     // Transmit frame strobe, low active
    localparam int PIN_SEL   = 3;                     // Register select
    localparam int PIN_SCLK  = 4;                     // Serial clock from host
    localparam int PIN_DIN   = 5;                     // Serial data from host
    localparam logic [5:0] PIN_RESET = 6'h16;         // Strobes and clock idle high

    // ************************************************************
    // Frame sequencer states
    // ************************************************************
    typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_DONE} ascs_state_e;

endpackage

// File: ascs_serial_port.sv
// Serial port front end of the converter with self and external clocking
`timescale 1ns/1ps

// What this block does
// (RULE_01) Mode pin high: drive serial clock out
// (RULE_02) Self mode: clock starts when strobe low
// (RULE_03) Self mode: release clock when strobe rises
// (RULE_04) Self mode: release clock after full word
// (RULE_05) Mode pin low: serial clock is input
// (RULE_06) External clock continuous or bursts both work
// (RULE_07) Select low: access control register
// (RULE_08) Select high: data or calibration registers
// (RULE_09) Host sets mode pin high or low
// (RULE_10) Host holds select stable through frame
module ascs_serial_port
    import ascs_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Mode and frame pins from host
    input  wire logic        clocking_mode,
    input  wire logic        receive_frame_strobe_n,
    input  wire logic        transmit_frame_strobe_n,
    input  wire logic        register_select,
    // Serial clock pin, split into three signals
    input  wire logic        serial_clock_in,
    output logic             serial_clock_out,
    output logic             serial_clock_oe,
    // Serial data pins
    input  wire logic        serial_data_in,
    output logic             serial_data_out,
    output logic             serial_data_oe,
    // Data ready flag to host
    output logic             conversion_ready_n,
    // Conversion results from the filter
    input  wire logic [23:0] sample_data,
    input  wire logic        sample_valid,
    output logic             sample_ready,
    // Register contents to the converter core
    output logic [23:0]      control_word,
    output logic [23:0]      calibration_word,
    output logic             calibration_write
);

    // ************************************************************
    // Declarations
    // ************************************************************
    logic [PIN_COUNT-1:0] pin_raw;                    // Pins gathered for synchronising
    logic [PIN_COUNT-1:0] sync1;                      // First stage, read by second only
    logic [PIN_COUNT-1:0] sync2;                      // Second stage
    logic [PIN_COUNT-1:0] sync3;                      // Third stage
    logic [PIN_COUNT-1:0] pin_f;                      // Settled pin levels
    logic                 sclk_prev;                  // Settled host clock, one cycle old
    ascs_state_e          state;                      // Frame sequencer
    ascs_state_e          next_state;                 // Sequencer next value
    logic                 self_q;                     // Self clocking for this frame
    logic                 is_read_q;                  // Frame reads from device
    logic                 sel_q;                      // Register select for this frame
    logic [4:0]           bit_cnt;                    // Bits moved in this word
    logic [23:0]          shift_out;                  // Word being sent
    logic [23:0]          shift_in;                   // Word being received
    logic [23:0]          next_in;                    // Received word with this bit
    logic                 sclk_gen;                   // Generated serial clock level
    logic [1:0]           half_cnt;                   // Cycles into half period
    logic                 rfs_low;                    // Receive strobe active
    logic                 tfs_low;                    // Transmit strobe active
    logic                 strobe_low;                 // Strobe of the running frame active
    logic                 gen_rise;                   // Generated clock rises this cycle
    logic                 gen_fall;                   // Generated clock falls this cycle
    logic                 ext_rise;                   // Host clock rose
    logic                 ext_fall;                   // Host clock fell
    logic                 rise_evt;                   // Sampling edge of the frame
    logic                 fall_evt;                   // Shifting edge of the frame
    logic                 word_done;                  // Last bit of a word taken
    logic                 next_self;                  // Clock mode after this edge
    logic [23:0]          fifo_data;                  // Oldest conversion result
    logic                 fifo_valid;                 // A result is waiting
    logic                 fifo_pop;                   // Result read out by host

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    assign pin_raw = {serial_data_in, serial_clock_in, register_select,
                      transmit_frame_strobe_n, receive_frame_strobe_n, clocking_mode};

    // Three flip-flop chain for every pin
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sync1 <= PIN_RESET;
            sync2 <= PIN_RESET;
            sync3 <= PIN_RESET;
        end
        else
        begin
            sync1 <= pin_raw;
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    // A level counts only once the last two stages agree
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            pin_f <= PIN_RESET;
        else
        begin
            for (int i = 0; i < PIN_COUNT; i++)
            begin
                if (sync2[i] == sync3[i])
                    pin_f[i] <= sync3[i];
            end
        end
    end

    // Previous host clock level for edge finding
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            sclk_prev <= 1'b1;
        else
            sclk_prev <= pin_f[PIN_SCLK];
    end

    // ************************************************************
    // Edge and frame decode
    // ************************************************************
    assign rfs_low    = ~pin_f[PIN_RFS];
    assign tfs_low    = ~pin_f[PIN_TFS];
    assign strobe_low = is_read_q ? rfs_low : tfs_low; // see RULE_03

    // Generated edges only while shifting in self mode
    assign gen_fall = self_q & (state == ST_SHIFT) & (half_cnt == HALF_CNT_LAST) & sclk_gen;
    assign gen_rise = self_q & (state == ST_SHIFT) & (half_cnt == HALF_CNT_LAST) & ~sclk_gen;

    // Host edges; a paused clock simply yields no edges, so bursts keep their place
    assign ext_rise = ~self_q & pin_f[PIN_SCLK] & ~sclk_prev;  // see RULE_05
    assign ext_fall = ~self_q & ~pin_f[PIN_SCLK] & sclk_prev;  // see RULE_06

    assign rise_evt  = (state == ST_SHIFT) & strobe_low & (gen_rise | ext_rise);
    assign fall_evt  = (state == ST_SHIFT) & strobe_low & (gen_fall | ext_fall);
    assign word_done = rise_evt & (bit_cnt == LAST_BIT_IDX);
    assign next_in   = {shift_in[22:0], pin_f[PIN_DIN]};
    assign next_self = (state == ST_IDLE) ? pin_f[PIN_MODE] : self_q;

    // Data results leave only on a completed data read
    assign fifo_pop = word_done & is_read_q & sel_q & fifo_valid;  // see RULE_08

    // ************************************************************
    // Frame sequencer
    // ************************************************************
    // Next state from strobes and word completion
    always_comb
    begin
        next_state = state;
        unique case (state)
            ST_IDLE:
            begin
                if (rfs_low | tfs_low)
                    next_state = ST_SHIFT;  // see RULE_02
            end
            ST_SHIFT:
            begin
                if (~strobe_low)
                    next_state = ST_IDLE;   // see RULE_03
                else if (word_done)
                    next_state = ST_DONE;   // see RULE_04
            end
            ST_DONE:
            begin
                if (~strobe_low)
                    next_state = ST_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            state <= ST_IDLE;
        else
            state <= next_state;
    end

    // Frame attributes caught as the frame opens
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            self_q    <= 1'b0;
            is_read_q <= 1'b0;
            sel_q     <= 1'b0;
        end
        else if ((state == ST_IDLE) && (rfs_low || tfs_low))
        begin
            self_q    <= pin_f[PIN_MODE];  // see RULE_01
            is_read_q <= rfs_low;
            sel_q     <= pin_f[PIN_SEL];   // see RULE_07
        end
    end

    // ************************************************************
    // Self clock generator
    // ************************************************************
    // Toggle every half period while a self clocked word runs
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sclk_gen <= 1'b1;
            half_cnt <= HALF_CNT_RESET;
        end
        else if (self_q && (state == ST_SHIFT) && strobe_low)
        begin
            if (half_cnt == HALF_CNT_LAST)
            begin
                half_cnt <= HALF_CNT_RESET;
                sclk_gen <= ~sclk_gen;     // see RULE_02
            end
            else
                half_cnt <= half_cnt + 2'h1;
        end
        else
        begin
            // Idle high between words
            sclk_gen <= 1'b1;
            half_cnt <= HALF_CNT_RESET;
        end
    end

    // ************************************************************
    // Shift registers
    // ************************************************************
    // Load on frame open, shift out on falling edges
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            shift_out <= EMPTY_WORD;
        else if ((state == ST_IDLE) && (rfs_low || tfs_low))
        begin
            if (pin_f[PIN_SEL])
                shift_out <= fifo_valid ? fifo_data : EMPTY_WORD;  // see RULE_08
            else
                shift_out <= control_word;                         // see RULE_07
        end
        else if (fall_evt && (bit_cnt != BIT_CNT_RESET))  // First fall keeps the top bit for rise one
            shift_out <= {shift_out[22:0], 1'b0};
    end

    // Sample input and count bits on rising edges
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            shift_in <= EMPTY_WORD;
            bit_cnt  <= BIT_CNT_RESET;
        end
        else if (state == ST_IDLE)
            bit_cnt <= BIT_CNT_RESET;
        else if (rise_evt)
        begin
            shift_in <= next_in;
            bit_cnt  <= bit_cnt + 5'h01;   // see RULE_06
        end
    end

    // ************************************************************
    // Register file
    // ************************************************************
    // Control word written when select is low
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            control_word <= CTRL_RESET;
        else if (word_done && !is_read_q && !sel_q)
            control_word <= next_in;       // see RULE_07
    end

    // Calibration word written when select is high
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            calibration_word  <= CAL_RESET;
            calibration_write <= 1'b0;
        end
        else
        begin
            calibration_write <= word_done & ~is_read_q & sel_q;
            if (word_done && !is_read_q && sel_q)
                calibration_word <= next_in;  // see RULE_08
        end
    end

    // ************************************************************
    // Pin drivers
    // ************************************************************
    // Serial clock driven only in self mode while a word runs
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            serial_clock_out <= 1'b1;
            serial_clock_oe  <= 1'b0;
        end
        else
        begin
            serial_clock_out <= sclk_gen;
            // Held until the clock is back high, so release never cuts a low phase
            serial_clock_oe  <= (next_self & (state == ST_SHIFT) & strobe_low)
                                | (serial_clock_oe & ~sclk_gen);  // see RULE_01
        end
    end

    // Data out driven through a read frame
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            serial_data_out <= 1'b0;
            serial_data_oe  <= 1'b0;
        end
        else
        begin
            serial_data_out <= shift_out[23];
            serial_data_oe  <= (state != ST_IDLE) & is_read_q & strobe_low;
        end
    end

    // Ready low while a result waits and no data read is under way
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            conversion_ready_n <= 1'b1;
        else
            conversion_ready_n <= ~fifo_valid | ((state != ST_IDLE) & is_read_q & sel_q);
    end

    // ************************************************************
    // Result buffer
    // ************************************************************
    ascs_fifo
    #(
        .WIDTH (WORD_BITS),
        .DEPTH (FIFO_DEPTH)
    )
    u_fifo
    (
        .clk       (clk),
        .rst       (rst),
        .in_data   (sample_data),
        .in_valid  (sample_valid),
        .in_ready  (sample_ready),
        .out_data  (fifo_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop)
    );

endmodule

// File: ascs_serial_port_props.sv
// Concurrent checks on the pins of the serial port front end
`timescale 1ns/1ps
module ascs_serial_port_props
    import ascs_pkg::*;
(
    // Clock and reset
    input wire logic        clk,
    input wire logic        rst,
    // Mode and frame pins
    input wire logic        clocking_mode,
    input wire logic        receive_frame_strobe_n,
    input wire logic        transmit_frame_strobe_n,
    input wire logic        register_select,
    // Serial pins
    input wire logic        serial_clock_out,
    input wire logic        serial_clock_oe,
    input wire logic        serial_data_oe,
    // Registers
    input wire logic [23:0] control_word,
    input wire logic        calibration_write
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // ************************************************************
    // Helper logic
    // ************************************************************
    logic       both_hi;   // No strobe active
    logic [5:0] rise_cnt;  // Generated rises in this frame
    assign both_hi = receive_frame_strobe_n & transmit_frame_strobe_n;
    // Count generated rises until both strobes are high again
    always_ff @(posedge clk)
    begin
        if (rst || both_hi)
            rise_cnt <= 6'h00;
        else if ($rose(serial_clock_out))
            rise_cnt <= rise_cnt + 6'h01;
    end

    // ************************************************************
    // Properties
    // ************************************************************
    sequence s_low_phase;
        !serial_clock_out ##1 (!serial_clock_out || !serial_clock_oe);
    endsequence
    property p_half;
        $fell(serial_clock_out) |-> s_low_phase ##1 (serial_clock_out || !serial_clock_oe);
    endproperty
    a_half: assert property (p_half) else $error("short low phase");
    property p_idle;
        !serial_clock_oe |-> serial_clock_out;
    endproperty
    a_idle: assert property (p_idle) else $error("released clock low");
    property p_start;
        clocking_mode && $fell(both_hi) |-> ##[2:6] serial_clock_oe;
    endproperty
    a_start: assert property (p_start) else $error("no clock after strobe");
    property p_stop;
        $rose(both_hi) |-> ##[1:6] !serial_clock_oe;
    endproperty
    a_stop: assert property (p_stop) else $error("clock after strobe high");
    property p_word;
        rise_cnt == 6'd24 |-> ##[0:3] !serial_clock_oe;
    endproperty
    a_word: assert property (p_word) else $error("clock after word");
    property p_max;
        serial_clock_oe |-> rise_cnt <= 6'd24;
    endproperty
    a_max: assert property (p_max) else $error("too many rises");
    property p_ext;
        (!clocking_mode) [*8] |-> !serial_clock_oe;
    endproperty
    a_ext: assert property (p_ext) else $error("external clock driven");
    property p_ctrl;
        $changed(control_word) |-> !register_select && !transmit_frame_strobe_n;
    endproperty
    a_ctrl: assert property (p_ctrl) else $error("bad control write");
    property p_cal;
        calibration_write |-> register_select && !transmit_frame_strobe_n;
    endproperty
    a_cal: assert property (p_cal) else $error("bad calibration write");
    property p_rd;
        $rose(serial_data_oe) |-> !receive_frame_strobe_n;
    endproperty
    a_rd: assert property (p_rd) else $error("data out of frame");
endmodule

// File: tb_ascs_serial_port.sv
// Self-checking bench for the serial port front end
`timescale 1ns/1ps
module tb_ascs_serial_port import ascs_pkg::*;;
    logic        clk, rst, mode, rfs_n, tfs_n, sel, h_sclk, h_sclk_oe, sdi;
    logic        sclk_out, sclk_oe, sdo, sdo_oe, rdy_n, s_valid, s_ready, cal_wr, sdo_last;
    logic [23:0] s_data, ctrl, cal, got;
    wire         sclk_w, sdo_w;
    int          bad_count, total_checks, rises, n;
    // Shared lines: clock pulled up
    assign sclk_w = sclk_oe ? sclk_out : (h_sclk_oe ? h_sclk : 1'b1);
    assign sdo_w = sdo_oe ? sdo : ~sdo_last;
    always @(posedge clk) if (sdo_oe) sdo_last <= sdo;

    ascs_serial_port i_dut (.clk(clk), .rst(rst), .clocking_mode(mode), .receive_frame_strobe_n(rfs_n),
        .transmit_frame_strobe_n(tfs_n), .register_select(sel), .serial_clock_in(sclk_w),
        .serial_clock_out(sclk_out), .serial_clock_oe(sclk_oe), .serial_data_in(sdi),
        .serial_data_out(sdo), .serial_data_oe(sdo_oe), .conversion_ready_n(rdy_n),
        .sample_data(s_data), .sample_valid(s_valid), .sample_ready(s_ready),
        .control_word(ctrl), .calibration_word(cal), .calibration_write(cal_wr));
    ascs_host_model i_host (.*);

    // Compare a word
    task automatic chk_word(input string nm, input logic [23:0] e, input logic [23:0] g);
        total_checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Compare a count
    task automatic chk_num(input string nm, input int e, input int g);
        total_checks++;
        if (g != e)
        begin
            bad_count++;
            $display("[ERR] %s expected %0d seen %0d", nm, e, g);
        end
    endtask
    // Sample value pushed at position k
    function automatic logic [23:0] val(input int k);
        return 24'h80_0001 + 24'(k) * 24'h03_0507;
    endfunction
    // Verdict and end of run
    task end_of_test;
        if (bad_count == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Push samples until the buffer refuses
    task t_fill;
        n = 0;
        repeat (24)
        begin
            @(negedge clk);
            s_data = val(n);
            s_valid = 1'b1;
            if (s_ready === 1'b1)
                n++;
        end
        @(negedge clk);
        s_valid = 1'b0;
        chk_num("fill count", FIFO_DEPTH, n);
        repeat (6) @(negedge clk);
        chk_word("ready_n full", 24'h00_0000, {23'h0, rdy_n});
    endtask
    // Writes in both clocking modes, short frame ignored
    task t_writes;
        i_host.xfer(0, 0, 0, 0, 24'hA5_3C96, 24, got, rises);
        chk_word("ctrl ext", 24'hA5_3C96, ctrl);
        i_host.xfer(0, 0, 1, 1, 24'h5A_C3E1, 24, got, rises);
        chk_word("cal burst", 24'h5A_C3E1, cal);
        chk_word("ctrl kept", 24'hA5_3C96, ctrl);
        i_host.xfer(0, 0, 0, 0, 24'h11_2233, 10, got, rises);
        chk_word("ctrl short", 24'hA5_3C96, ctrl);
        i_host.xfer(1, 0, 0, 0, 24'hFF_FFFF, 30, got, rises);
        chk_word("ctrl self", 24'hFF_FFFF, ctrl);
        chk_num("self rises", 24, rises);
    endtask
    // Reads: control, aborted, then every buffered word
    task t_reads;
        i_host.xfer(1, 1, 0, 0, '0, 24, got, rises);
        chk_word("read ctrl", 24'hFF_FFFF, got);
        i_host.xfer(1, 1, 1, 0, '0, 5, got, rises);
        chk_num("abort rises", 5, rises);
        i_host.xfer(0, 1, 1, 0, '0, 24, got, rises);
        chk_word("read ext", val(0), got);
        for (int i = 1; i < FIFO_DEPTH; i++)
        begin
            i_host.xfer(1, 1, 1, 0, '0, 30, got, rises);
            chk_word("read self", val(i), got);
        end
        repeat (6) @(negedge clk);
        chk_word("ready_n empty", 24'h00_0001, {23'h0, rdy_n});
    endtask

    // Clock
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Watchdog
    initial
    begin
        #400_000;
        bad_count++;
        end_of_test;
    end
    // Main sequence
    initial
    begin
        bad_count = 0;
        total_checks = 0;
        rst = 1'b1;
        s_valid = 1'b0;
        s_data = 24'h00_0000;
        sdo_last = 1'b0;
        repeat (2) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        chk_word("oe reset", 24'h00_0000, {23'h0, sclk_oe});
        chk_word("ctrl reset", CTRL_RESET, ctrl);
        repeat (4) @(negedge clk);
        t_writes;
        t_fill;
        t_reads;
        end_of_test;
    end
endmodule
bind ascs_serial_port ascs_serial_port_props i_props (.*);
